/* eqc_pkg.sv */
// constants and types of the equalizer configuration port
// Notes on behaviour
// - device acknowledges its own address with a low bit
// - host sends register pointer byte, device acknowledges it low
// - device acknowledges read address, sends pointed register msb first
// - status 0 holds detect flag in bit 0, revision above
// - status 1 and 2 show boost codes, status 1 bit 3 standby
// - register 3: lane0 disable, lane0 boost, clock disable; reset 0x77
// - register 4: lane2 disable and boost, lane1 disable and boost
// - register 5 bits 1:0 pick the detect assert level
// - register 6 bits 1:0 pick the detect deassert level
// - register 7 bit 0 picks pin or register enable control
// - register 8 bits 3:2 pick output swing; reset 0x78
// - chip select low ignores bus; high keeps port alive
// - respond only to address 1010110, write byte 0xac
// - register 7 bit 0 low: pin high gives active; set: register 3 bit 3 low gives active; else standby
// - detect flag rises above assert level, falls below deassert level
package eqc_pkg;
  localparam logic [6:0]       SLAVE_ADDR   = 7'h56;
  localparam logic [7:0]       PTR_STATUS0  = 8'h00;
  localparam logic [7:0]       PTR_STATUS1  = 8'h01;
  localparam logic [7:0]       PTR_STATUS2  = 8'h02;
  localparam logic [7:0]       PTR_CFG      = 8'h03;
  localparam logic [7:0]       PTR_LAST     = 8'h08;
  // index 0 is register 3, index 5 is register 8
  localparam logic [5:0][7:0]  CFG_RST      = {8'h78, 8'h00, 8'h00, 8'h00, 8'h77, 8'h77};
  localparam logic [5:0][7:0]  CFG_MASK     = {8'h0c, 8'h01, 8'h03, 8'h03, 8'hff, 8'hf8};
  localparam logic [2:0]       IX_LANE01    = 3'h0;
  localparam logic [2:0]       IX_LANE12    = 3'h1;
  localparam logic [2:0]       IX_ON        = 3'h2;
  localparam logic [2:0]       IX_OFF       = 3'h3;
  localparam logic [2:0]       IX_SRC       = 3'h4;
  localparam logic [2:0]       IX_SWING     = 3'h5;
  localparam int               AMP_MIN_W    = 11;
  // threshold levels in mV, indexed by code
  localparam logic [3:0][10:0] ON_MV        = {11'h04b, 11'h05a, 11'h037, 11'h046};
  localparam logic [3:0][10:0] OFF_MV       = {11'h02d, 11'h037, 11'h01e, 11'h028};
  localparam logic [3:0]       BIT_CNT_ACK  = 4'h8;
  localparam logic [3:0]       BIT_CNT_LAST = 4'h7;

  typedef enum logic [2:0] {
    EQC_IDLE, EQC_ADDR, EQC_PTR, EQC_WDATA, EQC_RDATA, EQC_DONE
  } eqc_phase_t;

  typedef struct packed {
    logic [2:0] lane_dis;
    logic       clk_dis;
    logic [2:0] boost2;
    logic [2:0] boost1;
    logic [2:0] boost0;
    logic [1:0] on_code;
    logic [1:0] off_code;
    logic [1:0] swing;
    logic       standby;
    logic       clock_presence_flag;
  } eqc_ctrl_t;
endpackage : eqc_pkg

/* eqc_config_port.sv */
// bus-clock sampler and configuration port of the equalizer
`timescale 1ns/100ps

module eqc_link_sampler (
  // link side
  input  wire logic link_clk_in,
  input  wire logic sda_in,
  input  wire logic rst_in,
  // core side
  output logic      bit_out,
  output logic      tog_out
);
  typedef struct packed {
    logic b;
    logic t;
  } eqc_link_t;
  eqc_link_t q;
  eqc_link_t next_q;

  always_comb begin
    next_q   = q;
    next_q.b = sda_in;
    next_q.t = ~q.t;
  end

  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign bit_out = q.b;
  assign tog_out = q.t;
endmodule : eqc_link_sampler

module eqc_config_port #(
  parameter int         AMP_W    = 11,
  parameter logic [3:0] REVISION = 4'h0  // arbitrary value
) (
  // clock, reset, enable
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             ce_in,
  // serial bus pins
  input  wire logic             bus_clock_pin_in,
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe_out,
  input  wire logic             chip_sel_in,
  // device pins
  input  wire logic             enable_pin_in,
  input  wire logic [AMP_W-1:0] clock_amplitude_in,
  // equalizer controls
  output eqc_pkg::eqc_ctrl_t    ctrl_out
);
  import eqc_pkg::*;

  if (AMP_W < AMP_MIN_W) begin : g_chk
    $error("amplitude width too small for threshold levels");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]       cs_s;
    logic [1:0]       scl_s;
    logic [1:0]       sda_s;
    logic [1:0]       en_s;
    logic [2:0]       tog_s;
    logic             scl_d;
    logic             sda_d;
    logic [AMP_W-1:0] amp_m;
    logic [AMP_W-1:0] amp_s;
    eqc_phase_t       st;
    logic [3:0]       cnt;
    logic [6:0]       sh;
    logic             ack;
    logic             rd;
    logic [7:0]       ptr;
    logic [7:0]       rbyte;
    logic [5:0][7:0]  cfg;
    logic [7:0]       stat1;
    logic [7:0]       stat2;
    logic             flag;
    logic             standby;
    logic             oe;
    logic             sda_lvl;
  } eqc_st_t;

  eqc_st_t          q;
  eqc_st_t          next_q;
  logic             link_bit;
  logic             link_tog;
  logic             bit_ev;
  logic             scl;
  logic             sda;
  logic             start;
  logic             stop;
  logic             fall;
  logic [7:0]       byte_in;
  logic [2:0]       widx;
  logic [AMP_W-1:0] on_lvl;
  logic [AMP_W-1:0] off_lvl;
  logic [7:0]       rd_val;

  eqc_link_sampler u_eqc_link_sampler (
    .link_clk_in (bus_clock_pin_in),
    .sda_in      (sda_in),
    .rst_in      (sys_rst_in),
    .bit_out     (link_bit),
    .tog_out     (link_tog)
  );

  assign bit_ev  = q.tog_s[2] ^ q.tog_s[1];
  assign scl     = q.scl_s[1];
  assign sda     = q.sda_s[1];
  assign start   = scl & q.scl_d & q.sda_d & ~sda;
  assign stop    = scl & q.scl_d & ~q.sda_d & sda;
  assign fall    = q.scl_d & ~scl;
  assign byte_in = {q.sh, link_bit};
  assign widx    = 3'(q.ptr - PTR_CFG);
  assign on_lvl  = AMP_W'(ON_MV[q.cfg[IX_ON][1:0]]);
  assign off_lvl = AMP_W'(OFF_MV[q.cfg[IX_OFF][1:0]]);

  // ---------------------------------------------------------------
  // register read mux
  // ---------------------------------------------------------------
  always_comb begin
    if (q.ptr == PTR_STATUS0) begin
      rd_val = {REVISION, 3'h0, q.flag};
    end else if (q.ptr == PTR_STATUS1) begin
      rd_val = q.stat1;
    end else if (q.ptr == PTR_STATUS2) begin
      rd_val = q.stat2;
    end else if (q.ptr <= PTR_LAST) begin
      rd_val = q.cfg[widx];
    end else begin
      rd_val = 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_q         = q;
    next_q.cs_s    = {q.cs_s[0], chip_sel_in};
    next_q.scl_s   = {q.scl_s[0], bus_clock_pin_in};
    next_q.sda_s   = {q.sda_s[0], sda_in};
    next_q.en_s    = {q.en_s[0], enable_pin_in};
    next_q.tog_s   = {q.tog_s[1:0], link_tog};
    next_q.amp_m   = clock_amplitude_in;
    next_q.amp_s   = q.amp_m;
    next_q.scl_d   = scl;
    next_q.sda_d   = sda;
    next_q.sda_lvl = 1'b0;
    // readback of settings in effect
    next_q.stat1   = {1'b0, q.cfg[IX_LANE01][6:4], q.standby, 3'h0};
    next_q.stat2   = {1'b0, q.cfg[IX_LANE12][6:4], 1'b0, q.cfg[IX_LANE12][2:0]};
    if (q.cfg[IX_SRC][0]) begin
      next_q.standby = q.cfg[IX_LANE01][3];
    end else begin
      next_q.standby = ~q.en_s[1];
    end
    if (q.flag) begin
      if (q.amp_s < off_lvl) begin
        next_q.flag = 1'b0;
      end
    end else if (q.amp_s > on_lvl) begin
      next_q.flag = 1'b1;
    end
    // bus protocol
    if (!q.cs_s[1] || stop) begin
      next_q.st = EQC_IDLE;
      next_q.oe = 1'b0;
    end else if (start) begin
      next_q.st  = EQC_ADDR;
      next_q.cnt = 4'h0;
      next_q.ack = 1'b0;
      next_q.oe  = 1'b0;
    end else if (bit_ev && q.st != EQC_IDLE && q.st != EQC_DONE) begin
      next_q.sh = byte_in[6:0];
      next_q.cnt = q.cnt + 4'h1;
      if (q.cnt == BIT_CNT_LAST) begin
        next_q.ack = 1'b1;
        case (q.st)
          EQC_ADDR: begin
            next_q.ack = (byte_in[7:1] == SLAVE_ADDR);
            next_q.rd  = byte_in[0];
          end
          EQC_PTR: begin
            next_q.ptr = byte_in;
          end
          EQC_WDATA: begin
            if (q.ptr >= PTR_CFG && q.ptr <= PTR_LAST) begin
              next_q.cfg[widx] = (q.cfg[widx] & ~CFG_MASK[widx])
                               | (byte_in & CFG_MASK[widx]);
            end
          end
          default: begin
            next_q.ack = 1'b0;
          end
        endcase
      end
      if (q.cnt == BIT_CNT_ACK) begin
        next_q.cnt = 4'h0;
        next_q.ack = 1'b0;
        case (q.st)
          EQC_ADDR: begin
            if (!q.ack) begin
              next_q.st = EQC_DONE;
            end else if (q.rd) begin
              next_q.st    = EQC_RDATA;
              next_q.rbyte = rd_val;
            end else begin
              next_q.st = EQC_PTR;
            end
          end
          EQC_PTR: begin
            next_q.st = EQC_WDATA;
          end
          EQC_RDATA: begin
            if (link_bit) begin
              next_q.st = EQC_DONE;
            end else begin
              next_q.rbyte = rd_val;
            end
          end
          default: begin
            next_q.st = q.st;
          end
        endcase
      end
    end else if (fall) begin
      if (q.st == EQC_RDATA) begin
        next_q.oe = (q.cnt < BIT_CNT_ACK) && !q.rbyte[3'(BIT_CNT_LAST - q.cnt)];
      end else begin
        next_q.oe = (q.cnt == BIT_CNT_ACK) && q.ack;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      q     <= '0;
      q.st  <= EQC_IDLE;
      q.cfg <= CFG_RST;
    end else if (ce_in) begin
      q <= next_q;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign sda_out                      = q.sda_lvl;
  assign sda_oe_out                   = q.oe;
  assign ctrl_out.lane_dis            = {q.cfg[IX_LANE12][7], q.cfg[IX_LANE12][3],
                                         q.cfg[IX_LANE01][7]};
  assign ctrl_out.clk_dis             = q.cfg[IX_LANE01][3];
  assign ctrl_out.boost2              = q.cfg[IX_LANE12][6:4];
  assign ctrl_out.boost1              = q.cfg[IX_LANE12][2:0];
  assign ctrl_out.boost0              = q.cfg[IX_LANE01][6:4];
  assign ctrl_out.on_code             = q.cfg[IX_ON][1:0];
  assign ctrl_out.off_code            = q.cfg[IX_OFF][1:0];
  assign ctrl_out.swing               = q.cfg[IX_SWING][3:2];
  assign ctrl_out.standby             = q.standby;
  assign ctrl_out.clock_presence_flag = q.flag;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in || !ce_in);

  sequence byte_end;
    bit_ev && q.cs_s[1] && !start && !stop && q.cnt == BIT_CNT_LAST;
  endsequence
  sequence ack_slot;
    bit_ev && q.cs_s[1] && !start && !stop && q.cnt == BIT_CNT_ACK;
  endsequence

  addr_ack_a: assert property (byte_end ##0 (q.st == EQC_ADDR)
      |=> q.ack == ($past(byte_in[7:1]) == SLAVE_ADDR))
    else $error("address acknowledge does not match slave address");
  ptr_take_a: assert property (byte_end ##0 (q.st == EQC_PTR)
      |=> q.ack && q.ptr == $past(byte_in) && q.cnt == BIT_CNT_ACK)
    else $error("pointer byte not taken and acknowledged");
  ack_drive_a: assert property ((q.cnt == BIT_CNT_ACK && q.ack && fall
      && q.cs_s[1] && !start && !stop && !bit_ev && q.st != EQC_RDATA) |=> q.oe)
    else $error("acknowledge not driven low");
  read_load_a: assert property (ack_slot ##0 (q.st == EQC_ADDR && q.ack && q.rd)
      |=> q.st == EQC_RDATA && q.rbyte == $past(rd_val))
    else $error("read data not loaded after read address");
  high_ptr_a: assert property ((q.ptr > PTR_LAST) |-> rd_val == 8'h00)
    else $error("pointer above eight reads nonzero");
  cs_quiet_a: assert property (!q.cs_s[1] |=> q.st == EQC_IDLE ##1 !q.oe)
    else $error("bus port active while deselected");
  ro_write_a: assert property ((byte_end ##0 q.st == EQC_WDATA && q.ptr < PTR_CFG)
      |=> $stable(q.cfg))
    else $error("write to read-only register changed state");
  flag_hyst_a: assert property ((q.flag && q.amp_s >= off_lvl) |=> q.flag)
    else $error("detect flag fell above deassert level");
  src_pin_a: assert property ((!q.cfg[IX_SRC][0] && $stable(q.cfg)
      && $stable(q.en_s[1]))[*2] |-> q.standby == !q.en_s[1])
    else $error("standby does not follow enable pin");
endmodule : eqc_config_port

/* eqc_host_model.sv */
// bus host model that drives chip select, bus clock and data line
`timescale 1ns/100ps
module eqc_host_model (
  // bus wires
  output logic      scl_out,
  output logic      low_out,
  output logic      cs_out,
  input  wire logic sda_in
);
  // ----------------------------------------
  // bit, byte and transfer tasks
  // ----------------------------------------
  initial begin
    scl_out = 1'b1;
    low_out = 1'b0;
    cs_out  = 1'b0;
  end
  // clock stands high between frames
  task automatic put_bit(input logic b, output logic s);
    #12 low_out = ~b;
    #12 scl_out = 1'b1;
    #23 s = sda_in;
    #1 scl_out = 1'b0;
  endtask : put_bit
  task automatic start_c();
    #12 low_out = 1'b0;
    #12 scl_out = 1'b1;
    #24 low_out = 1'b1;
    #24 scl_out = 1'b0;
  endtask : start_c
  task automatic stop_c();
    #12 low_out = 1'b1;
    #12 scl_out = 1'b1;
    #24 low_out = 1'b0;
    #48;
  endtask : stop_c
  // ninth slot: released by host, ack is a low line
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], s);
      q[i] = s;
    end
    put_bit(1'b1, s);
    ack = ~s;
  endtask : xfer
  task automatic wr(input logic sel, input logic [6:0] a, input logic [7:0] p, d,
                    output logic [2:0] ak);
    logic [7:0] q;
    cs_out = sel;
    start_c();
    xfer({a, 1'b0}, q, ak[2]);
    xfer(p, q, ak[1]);
    xfer(d, q, ak[0]);
    stop_c();
    cs_out = 1'b0;
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] q,
                    output logic [2:0] ak);
    logic x;
    cs_out = 1'b1;
    start_c();
    xfer({a, 1'b0}, q, ak[2]);
    xfer(p, q, ak[1]);
    start_c();
    xfer({a, 1'b1}, q, ak[0]);
    xfer(8'hff, q, x);
    stop_c();
    cs_out = 1'b0;
  endtask : rd
endmodule : eqc_host_model

/* tb_eqc_config_port.sv */
// self-checking testbench of the equalizer configuration port
`timescale 1ns/100ps
module tb_eqc_config_port;
  import eqc_pkg::*;
  logic        clk_in        = 1'b0;
  logic        sys_rst_in    = 1'b1;
  logic        enable_pin_in = 1'b1;
  logic [10:0] amp           = 11'h000;
  logic        sda_oe;
  logic        sda_lvl;
  logic        scl;
  logic        low;
  logic        cs;
  wire         sda = ~low & (sda_oe ? sda_lvl : 1'b1);
  eqc_ctrl_t   ctrl;
  int          err_count     = 0;
  int          checked       = 0;
  logic [7:0]  q;
  logic [2:0]  ak;
  logic [7:0]  rst_v [9] = '{8'h00, 8'h70, 8'h77, 8'h77, 8'h77, 8'h00, 8'h00, 8'h00, 8'h78};
  logic [7:0]  ff_v [6]  = '{8'hff, 8'hff, 8'h03, 8'h03, 8'h01, 8'h7c};
  int          on_t [4]  = '{70, 55, 90, 75};
  int          off_t [4] = '{40, 30, 55, 45};

  always #2.5 clk_in = ~clk_in;

  eqc_config_port #(.AMP_W(11), .REVISION(4'h0)) u_eqc_config_port (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(1'b1),
    .bus_clock_pin_in(scl), .sda_in(sda), .sda_out(sda_lvl), .sda_oe_out(sda_oe),
    .chip_sel_in(cs), .enable_pin_in(enable_pin_in), .clock_amplitude_in(amp),
    .ctrl_out(ctrl));
  eqc_host_model u_eqc_host_model (.scl_out(scl), .low_out(low), .cs_out(cs), .sda_in(sda));

  task automatic chk(input logic [7:0] g, e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] p, e);
    u_eqc_host_model.rd(SLAVE_ADDR, p, q, ak);
    chk({5'h0, ak}, 8'h07);
    chk(q, e);
  endtask : rchk
  task automatic wrt(input logic [7:0] p, d);
    u_eqc_host_model.wr(1'b1, SLAVE_ADDR, p, d, ak);
    chk({5'h0, ak}, 8'h07);
  endtask : wrt
  task automatic pause();
    repeat (8) @(negedge clk_in);
  endtask : pause
  // pin levels change on a falling edge, then settle
  task automatic set_in(input logic [10:0] a, input logic e);
    @(negedge clk_in);
    amp           = a;
    enable_pin_in = e;
    repeat (8) @(negedge clk_in);
  endtask : set_in
  task automatic final_report();
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  initial begin
    #400000;
    err_count++;
    final_report();
  end

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    repeat (3) @(negedge clk_in);
    sys_rst_in = 1'b0;
    pause();
    foreach (rst_v[i]) rchk(8'(i), rst_v[i]);
    for (int i = 3; i <= 8; i++) wrt(8'(i), 8'hff);
    foreach (ff_v[i]) rchk(8'(i + 3), ff_v[i]);
    wrt(8'h00, 8'hff);
    rchk(8'h00, 8'h00);
    rchk(8'h01, 8'h78);
    rchk(8'h09, 8'h00);
    wrt(8'h03, 8'ha8);
    wrt(8'h04, 8'h3d);
    chk({1'b0, ctrl.lane_dis, ctrl.clk_dis, ctrl.boost0}, 8'h3a);
    chk({2'h0, ctrl.boost2, ctrl.boost1}, 8'h1d);
    rchk(8'h02, 8'h35);
    rchk(8'h01, 8'h28);
    wrt(8'h03, 8'ha0);
    chk({7'h0, ctrl.standby}, 8'h00);
    wrt(8'h07, 8'h00);
    set_in(11'h000, 1'b0);
    chk({7'h0, ctrl.standby}, 8'h01);
    set_in(11'h000, 1'b1);
    chk({7'h0, ctrl.standby}, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wrt(8'h08, {4'h7, 2'(s), 2'h0});
      chk({6'h0, ctrl.swing}, 8'(s));
    end
    for (int c = 0; c < 4; c++) begin
      // start each level below both thresholds so the rise is real
      set_in(11'h000, 1'b1);
      wrt(8'h05, 8'(c));
      wrt(8'h06, 8'(c));
      set_in(11'(on_t[c]), 1'b1);
      chk({7'h0, ctrl.clock_presence_flag}, 8'h00);
      set_in(11'(on_t[c] + 1), 1'b1);
      chk({7'h0, ctrl.clock_presence_flag}, 8'h01);
      set_in(11'(off_t[c]), 1'b1);
      chk({7'h0, ctrl.clock_presence_flag}, 8'h01);
      if (c == 0) rchk(8'h00, 8'h01);
      set_in(11'(off_t[c] - 1), 1'b1);
      chk({7'h0, ctrl.clock_presence_flag}, 8'h00);
    end
    u_eqc_host_model.wr(1'b1, 7'h57, 8'h05, 8'h00, ak);
    chk({5'h0, ak}, 8'h00);
    u_eqc_host_model.wr(1'b0, SLAVE_ADDR, 8'h05, 8'h00, ak);
    chk({5'h0, ak}, 8'h00);
    rchk(8'h05, 8'h03);
    final_report();
  end
endmodule : tb_eqc_config_port
